// File: hdl/alarm_defines.svh
// Address map, reset values and timing constants of the leaky-bucket alarm
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// Time base
`define CLK_MHZ          100
`define CYCLE_MS         128
`define CYCLE_CLKS       (`CYCLE_MS * 1000 * `CLK_MHZ)
`define CYC_W            24

// Register addresses on the serial port
`define ADDR_SET         7'h5C
`define ADDR_CLEAR       7'h5D
`define ADDR_CEIL        7'h5E
`define ADDR_LEAK        7'h5F
`define ADDR_FILL        7'h60

// Reset values
`define RST_SET          8'h06
`define RST_CLEAR        8'h04
`define RST_CEIL         8'h08
`define RST_LEAK         8'h01

// Leak-rate field and serial frame layout
`define LEAK_MSB         1
`define LEAK_LSB         0
`define ADDR_LAST_BIT    3'h7
`define DATA_LAST_BIT    3'h7

`endif

// File: hdl/alarm_pkg.sv
// Types shared by the leaky-bucket alarm design
package alarm_pkg;

    // Serial frame states, Gray coded along the frame
    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_ADDR = 2'b01,
        SP_DATA = 2'b11,
        SP_HOLD = 2'b10
    } sp_state_t;

    typedef logic [7:0] byte_t;

endpackage

// File: hdl/leaky_bucket_activity_alarm.sv
// Leaky-bucket inactivity alarm with its serially programmed configuration set
`timescale 1ns/10ps
`default_nettype none
`include "alarm_defines.svh"

// Notes on behaviour
// - Judge input once per 128 ms cycle
// - Failed or erratic cycle adds one
// - Each clean leak period subtracts one
// - Leak period 1, 2, 4, 8 cycles
// - Raise alarm when count reaches set level
// - Clear alarm at clear level, reset 4
// - Count saturates at ceiling, reset 8
module leaky_bucket_activity_alarm #(
    parameter int unsigned CYCLE_TICKS = `CYCLE_CLKS
) (
    input  wire logic REF_CLK,
    input  wire logic RESETN,
    input  wire logic INPUT_BAD,
    input  wire logic SCLK,
    input  wire logic CS_N,
    input  wire logic SDI,
    output logic      SDO,
    output logic      SDO_OE,
    output logic      ALARM
);

    logic                 rst_meta;
    logic                 rst_n;
    logic [3:0]           pin_meta;
    logic [3:0]           pin_sync;
    logic                 bad_s;
    logic                 sclk_s;
    logic                 cs_n_s;
    logic                 sdi_s;
    logic [`CYC_W-1:0]    cyc_cnt;
    logic [`CYC_W-1:0]    next_cyc_cnt;
    logic                 tick;
    logic                 next_tick;
    logic                 bad_seen;
    logic                 next_bad_seen;
    logic                 cycle_bad;
    logic [7:0]           fill;
    logic [7:0]           next_fill;
    logic [2:0]           leak_cnt;
    logic [2:0]           next_leak_cnt;
    logic                 next_alarm;
    alarm_pkg::byte_t     set_level;
    alarm_pkg::byte_t     clear_level;
    alarm_pkg::byte_t     ceiling;
    alarm_pkg::byte_t     leak_sel;
    alarm_pkg::byte_t     next_set_level;
    alarm_pkg::byte_t     next_clear_level;
    alarm_pkg::byte_t     next_ceiling;
    alarm_pkg::byte_t     next_leak_sel;
    logic [6:0]           sp_addr;
    logic                 wr_stb;
    alarm_pkg::byte_t     wr_data;
    alarm_pkg::byte_t     rd_data;

    // Last leak-counter value of a period of 1, 2, 4 or 8 cycles
    function automatic logic [2:0] leak_last(input logic [1:0] sel);
        leak_last = 3'((4'h1 << sel) - 4'h1);
    endfunction

    // Read-back value of an address; unmapped addresses read zero
    function automatic alarm_pkg::byte_t reg_read(input logic [6:0] a);
        case (a)
            `ADDR_SET:   reg_read = set_level;
            `ADDR_CLEAR: reg_read = clear_level;
            `ADDR_CEIL:  reg_read = ceiling;
            `ADDR_LEAK:  reg_read = {6'h00, leak_sel[`LEAK_MSB:`LEAK_LSB]};
            `ADDR_FILL:  reg_read = fill;
            default:     reg_read = 8'h00;
        endcase
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Two-flop synchronisers for every pin input
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= 4'h2;  // Chip select idles high
            pin_sync <= 4'h2;
        end
        else
        begin
            pin_meta <= {INPUT_BAD, SDI, CS_N, SCLK};
            pin_sync <= pin_meta;
        end
    end

    assign sclk_s = pin_sync[0];
    assign cs_n_s = pin_sync[1];
    assign sdi_s  = pin_sync[2];
    assign bad_s  = pin_sync[3];

    // Evaluation cycle divider and failure capture within the cycle
    assign cycle_bad = bad_seen | bad_s;

    always_comb
    begin
        next_tick     = (cyc_cnt == `CYC_W'(CYCLE_TICKS - 1));
        next_cyc_cnt  = next_tick ? '0 : cyc_cnt + `CYC_W'(1);
        next_bad_seen = tick ? 1'b0 : cycle_bad;
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_cnt  <= '0;
            tick     <= 1'b0;
            bad_seen <= 1'b0;
        end
        else
        begin
            cyc_cnt  <= next_cyc_cnt;
            tick     <= next_tick;
            bad_seen <= next_bad_seen;
        end
    end

    // Bucket fill, leak and alarm hysteresis, updated once per cycle
    always_comb
    begin
        next_fill     = fill;
        next_leak_cnt = leak_cnt;
        next_alarm    = ALARM;
        if (tick)
        begin
            if (cycle_bad)
            begin
                next_leak_cnt = 3'h0;
                next_fill = (fill >= ceiling) ? ceiling : fill + 8'h01;
            end
            // At or past the period end leaks at once, so a shortened period never stalls
            else if (leak_cnt >= leak_last(leak_sel[`LEAK_MSB:`LEAK_LSB]))
            begin
                next_leak_cnt = 3'h0;
                next_fill = (fill == 8'h00) ? 8'h00 : fill - 8'h01;
            end
            else
            begin
                next_leak_cnt = leak_cnt + 3'h1;
            end
            if (!ALARM && next_fill >= set_level)
            begin
                next_alarm = 1'b1;
            end
            else if (ALARM && next_fill <= clear_level)
            begin
                next_alarm = 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fill     <= 8'h00;
            leak_cnt <= 3'h0;
            ALARM    <= 1'b0;
        end
        else
        begin
            fill     <= next_fill;
            leak_cnt <= next_leak_cnt;
            ALARM    <= next_alarm;
        end
    end

    // Configuration registers written from the serial port
    always_comb
    begin
        next_set_level   = set_level;
        next_clear_level = clear_level;
        next_ceiling     = ceiling;
        next_leak_sel    = leak_sel;
        if (wr_stb)
        begin
            case (sp_addr)
                `ADDR_SET:   next_set_level   = wr_data;
                `ADDR_CLEAR: next_clear_level = wr_data;
                `ADDR_CEIL:  next_ceiling     = wr_data;
                `ADDR_LEAK:  next_leak_sel    = {6'h00, wr_data[`LEAK_MSB:`LEAK_LSB]};
                default:     next_leak_sel    = leak_sel;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            set_level   <= `RST_SET;
            clear_level <= `RST_CLEAR;
            ceiling     <= `RST_CEIL;
            leak_sel    <= `RST_LEAK;
        end
        else
        begin
            set_level   <= next_set_level;
            clear_level <= next_clear_level;
            ceiling     <= next_ceiling;
            leak_sel    <= next_leak_sel;
        end
    end

    assign rd_data = reg_read(sp_addr);

    // Serial register port
    serial_port u_serial_port (
        .clk     (REF_CLK),
        .rst_n   (rst_n),
        .sclk    (sclk_s),
        .cs_n    (cs_n_s),
        .sdi     (sdi_s),
        .rd_data (rd_data),
        .addr    (sp_addr),
        .wr_stb  (wr_stb),
        .wr_data (wr_data),
        .sdo     (SDO),
        .sdo_oe  (SDO_OE)
    );

    // Checks on the bucket behaviour
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!rst_n);

    cycle_tick_a: assert property (
        tick |-> $past(cyc_cnt) == `CYC_W'(CYCLE_TICKS - 1) && cyc_cnt == '0)
        else $error("cycle tick not at end of cycle count");
    fill_step_a: assert property (
        tick && cycle_bad && fill < ceiling |=> fill == $past(fill) + 8'h01)
        else $error("failed cycle did not add one");
    leak_step_a: assert property (
        tick && !cycle_bad && fill != 8'h00
        && leak_cnt >= leak_last(leak_sel[`LEAK_MSB:`LEAK_LSB]) |=> fill == $past(fill) - 8'h01)
        else $error("leak period did not subtract one");
    leak_wait_a: assert property (
        tick && !cycle_bad && leak_cnt < leak_last(leak_sel[`LEAK_MSB:`LEAK_LSB])
        |=> fill == $past(fill) && leak_cnt == $past(leak_cnt) + 3'h1)
        else $error("fill moved before leak period ended");
    alarm_raise_a: assert property (
        $past(tick) && !$past(ALARM) && fill >= $past(set_level) |-> ALARM)
        else $error("alarm not raised at set level");
    alarm_clear_a: assert property (
        $past(tick) && $past(ALARM) && fill <= $past(clear_level) |-> !ALARM)
        else $error("alarm not cleared at clear level");
    ceiling_cap_a: assert property (
        tick && cycle_bad && fill >= ceiling |=> fill == $past(ceiling))
        else $error("fill passed the ceiling");
    floor_hold_a: assert property (
        tick && !cycle_bad && fill == 8'h00 |=> fill == 8'h00)
        else $error("fill went below zero");
    alarm_timing_a: assert property (
        $changed(ALARM) |-> $past(tick))
        else $error("alarm changed outside a cycle boundary");

endmodule
`default_nettype wire

// File: hdl/serial_port.sv
// Serial register port: 1 direction bit, 7 address bits, 8 data bits, MSB first
`timescale 1ns/10ps
`default_nettype none
`include "alarm_defines.svh"

module serial_port (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              sdi,
    input  wire alarm_pkg::byte_t  rd_data,
    output logic [6:0]             addr,
    output logic                   wr_stb,
    output alarm_pkg::byte_t       wr_data,
    output logic                   sdo,
    output logic                   sdo_oe
);

    alarm_pkg::sp_state_t state;
    alarm_pkg::sp_state_t next_state;
    logic                 sclk_d;
    logic [2:0]           bit_cnt;
    logic [2:0]           next_bit_cnt;
    logic [7:0]           shift;
    logic [7:0]           next_shift;
    logic [7:0]           out_sh;
    logic [7:0]           next_out_sh;
    logic                 is_read;
    logic                 next_is_read;
    logic [6:0]           next_addr;
    logic                 next_wr_stb;
    logic [7:0]           next_wr_data;
    logic                 next_sdo;
    logic                 next_sdo_oe;
    logic                 rise;
    logic                 fall;

    // Edges of the already synchronised serial clock
    assign rise = sclk & ~sclk_d;
    assign fall = ~sclk & sclk_d;

    // Frame sequencing: sample on rising edges, shift read data on falling edges
    always_comb
    begin
        next_state   = state;
        next_bit_cnt = bit_cnt;
        next_shift   = shift;
        next_out_sh  = out_sh;
        next_is_read = is_read;
        next_addr    = addr;
        next_wr_stb  = 1'b0;
        next_wr_data = wr_data;
        next_sdo     = sdo;
        next_sdo_oe  = 1'b0;
        if (cs_n)
        begin
            next_state   = alarm_pkg::SP_IDLE;
            next_bit_cnt = 3'h0;
        end
        else
        begin
            case (state)
                alarm_pkg::SP_IDLE:
                begin
                    next_state   = alarm_pkg::SP_ADDR;
                    next_bit_cnt = 3'h0;
                end
                alarm_pkg::SP_ADDR:
                begin
                    if (rise)
                    begin
                        next_shift   = {shift[6:0], sdi};
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == `ADDR_LAST_BIT)
                        begin
                            next_is_read = shift[6];
                            next_addr    = {shift[5:0], sdi};
                            next_state   = alarm_pkg::SP_DATA;
                        end
                    end
                end
                alarm_pkg::SP_DATA:
                begin
                    next_sdo_oe = is_read;
                    if (fall)
                    begin
                        // First falling edge presents the MSB of the addressed register
                        if (bit_cnt == 3'h0)
                        begin
                            next_sdo    = rd_data[7];
                            next_out_sh = {rd_data[6:0], 1'b0};
                        end
                        else
                        begin
                            next_sdo    = out_sh[7];
                            next_out_sh = {out_sh[6:0], 1'b0};
                        end
                    end
                    if (rise)
                    begin
                        next_shift   = {shift[6:0], sdi};
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == `DATA_LAST_BIT)
                        begin
                            next_wr_stb  = ~is_read;
                            next_wr_data = {shift[6:0], sdi};
                            next_state   = alarm_pkg::SP_HOLD;
                        end
                    end
                end
                alarm_pkg::SP_HOLD:
                begin
                    next_state = alarm_pkg::SP_HOLD;  // Wait for chip select to return high
                end
                default:
                begin
                    next_state = alarm_pkg::SP_IDLE;
                end
            endcase
        end
    end

    // Frame registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state   <= alarm_pkg::SP_IDLE;
            sclk_d  <= 1'b0;
            bit_cnt <= 3'h0;
            shift   <= 8'h00;
            out_sh  <= 8'h00;
            is_read <= 1'b0;
            addr    <= 7'h00;
            wr_stb  <= 1'b0;
            wr_data <= 8'h00;
            sdo     <= 1'b0;
            sdo_oe  <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            sclk_d  <= sclk;
            bit_cnt <= next_bit_cnt;
            shift   <= next_shift;
            out_sh  <= next_out_sh;
            is_read <= next_is_read;
            addr    <= next_addr;
            wr_stb  <= next_wr_stb;
            wr_data <= next_wr_data;
            sdo     <= next_sdo;
            sdo_oe  <= next_sdo_oe;
        end
    end

endmodule
`default_nettype wire

// File: verification/leaky_bucket_activity_alarm_tb.sv
// Self-checking testbench of the leaky-bucket inactivity alarm
`timescale 1ns/10ps
`default_nettype none
`include "alarm_defines.svh"

module leaky_bucket_activity_alarm_tb;

    localparam int unsigned CT = 800;

    logic REF_CLK;
    logic RESETN;
    logic INPUT_BAD;
    logic SCLK;
    logic CS_N;
    logic SDI;
    logic SDO;
    logic SDO_OE;
    logic ALARM;
    int   err_count;
    int   checked;
    logic [7:0] rd;

    // Short tick period keeps a bucket walk within a few tens of thousands of cycles
    leaky_bucket_activity_alarm #(
        .CYCLE_TICKS (CT)
    ) u_leaky_bucket_activity_alarm (
        .REF_CLK   (REF_CLK),
        .RESETN    (RESETN),
        .INPUT_BAD (INPUT_BAD),
        .SCLK      (SCLK),
        .CS_N      (CS_N),
        .SDI       (SDI),
        .SDO       (SDO),
        .SDO_OE    (SDO_OE),
        .ALARM     (ALARM)
    );

    // Free-running 100 MHz clock
    initial
    begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    // Compare one value and count the outcome
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One serial frame: direction bit, 7 address bits, 8 data bits, MSB first
    task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        logic [15:0] w;
        w = {rw, a, d};
        q = 8'h00;
        CS_N = 1'b0;
        repeat (8) @(negedge REF_CLK);
        for (int i = 15; i >= 0; i--)
        begin
            SDI = w[i];
            repeat (8) @(negedge REF_CLK);
            if (rw && i < 8)
            begin
                q[i] = SDO;
                check({7'h00, SDO_OE}, 8'h01, "output enable in read data phase");
            end
            else if (!rw && i < 8)
            begin
                check({7'h00, SDO_OE}, 8'h00, "output enable low in write data phase");
            end
            SCLK = 1'b1;
            repeat (8) @(negedge REF_CLK);
            SCLK = 1'b0;
        end
        repeat (6) @(negedge REF_CLK);
        CS_N = 1'b1;
        SDI = 1'b0;
        repeat (8) @(negedge REF_CLK);
    endtask

    // Register write and register read-compare
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        frame(1'b0, a, d, rd);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
        frame(1'b1, a, 8'h00, rd);
        check(rd, exp, what);
    endtask

    // Reset values, unmapped read and written values read back
    task automatic t_registers;
        rd_chk(`ADDR_SET, `RST_SET, "set level reset");
        rd_chk(`ADDR_CLEAR, 8'h04, "clear level reset");
        rd_chk(`ADDR_CEIL, 8'h08, "ceiling reset");
        rd_chk(`ADDR_LEAK, 8'h01, "leak select reset");
        rd_chk(7'h70, 8'h00, "unmapped read");
        wr(`ADDR_LEAK, 8'hFF);
        rd_chk(`ADDR_LEAK, 8'h03, "leak select unused bits");
        wr(`ADDR_SET, 8'h05);
        wr(`ADDR_CLEAR, 8'h03);
        wr(`ADDR_CEIL, 8'h07);
        wr(`ADDR_LEAK, 8'h00);
        rd_chk(`ADDR_SET, 8'h05, "set level written");
        rd_chk(`ADDR_CLEAR, 8'h03, "clear level written");
        rd_chk(`ADDR_CEIL, 8'h07, "ceiling written");
        $display("test registers done");
    endtask

    // Fill to the set level, saturate, leak through hysteresis down to the floor
    task automatic t_alarm_cycle;
        int n;
        INPUT_BAD = 1'b1;
        n = 0;
        while (n < 12 * CT && ALARM !== 1'b1)
        begin
            @(negedge REF_CLK);
            n++;
        end
        check({7'h00, ALARM}, 8'h01, "alarm raised");
        repeat (CT / 2) @(negedge REF_CLK);
        rd_chk(`ADDR_FILL, 8'h05, "fill at alarm raise");
        check({7'h00, ALARM}, 8'h01, "alarm held while bad");
        repeat (3 * CT) @(negedge REF_CLK);
        rd_chk(`ADDR_FILL, 8'h07, "fill capped at ceiling");
        INPUT_BAD = 1'b0;
        repeat (4 * CT) @(negedge REF_CLK);
        rd_chk(`ADDR_FILL, 8'h04, "fill above clear level");
        check({7'h00, ALARM}, 8'h01, "alarm kept above clear level");
        repeat (CT) @(negedge REF_CLK);
        rd_chk(`ADDR_FILL, 8'h03, "fill at clear level");
        check({7'h00, ALARM}, 8'h00, "alarm cleared at clear level");
        repeat (5 * CT) @(negedge REF_CLK);
        rd_chk(`ADDR_FILL, 8'h00, "fill floor");
        check({7'h00, ALARM}, 8'h00, "alarm stays clear");
        $display("test alarm cycle done");
    endtask

    // Each slower leak period: no decrement after L-1 clean cycles, one after L
    task automatic t_leak_rates;
        logic [7:0] f;
        int         len;
        f = 8'h00;
        for (int sel = 1; sel < 4; sel++)
        begin
            len = 1 << sel;
            wr(`ADDR_LEAK, 8'(sel));
            INPUT_BAD = 1'b1;
            repeat (CT) @(negedge REF_CLK);
            INPUT_BAD = 1'b0;
            f = f + 8'h02;
            repeat (len * CT) @(negedge REF_CLK);
            rd_chk(`ADDR_FILL, f, "fill before leak period ends");
            repeat (CT) @(negedge REF_CLK);
            f = f - 8'h01;
            rd_chk(`ADDR_FILL, f, "fill after one leak period");
        end
        $display("test leak rates done");
    endtask

    // Verdict and end of run
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Cuts a hang short well after the expected run length
    initial
    begin
        repeat (70000) @(posedge REF_CLK);
        err_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        final_report();
    end

    // Main sequence
    initial
    begin
        err_count = 0;
        checked = 0;
        RESETN = 1'b0;
        INPUT_BAD = 1'b0;
        SCLK = 1'b0;
        CS_N = 1'b1;
        SDI = 1'b0;
        repeat (8) @(negedge REF_CLK);
        RESETN = 1'b1;
        repeat (8) @(negedge REF_CLK);
        check({5'h00, SDO, SDO_OE, ALARM}, 8'h00, "outputs after reset");
        t_registers();
        t_alarm_cycle();
        t_leak_rates();
        final_report();
    end

endmodule
`default_nettype wire
